// file: core/flash_host_map.svh
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

// --------------------------------------------------------------
// clock and timing
// --------------------------------------------------------------
`define FH_CLK_PERIOD_NS 50
`define FH_WE_LOW_NS 100
`define FH_WE_LOW_CYC ((`FH_WE_LOW_NS + `FH_CLK_PERIOD_NS - 1) / `FH_CLK_PERIOD_NS)
`define FH_RD_ACC_NS 150
`define FH_RD_WAIT_CYC ((`FH_RD_ACC_NS + `FH_CLK_PERIOD_NS - 1) / `FH_CLK_PERIOD_NS + 1)
`define FH_LOAD_WIN_NS 150000
`define FH_LOAD_WIN_CYC (`FH_LOAD_WIN_NS / `FH_CLK_PERIOD_NS)
`define FH_LOAD_MARGIN_CYC 200
`define FH_PWRUP_MS 5
`define FH_PWRUP_CYC (`FH_PWRUP_MS * 1000000 / `FH_CLK_PERIOD_NS)
`define FH_PROG_CYCLE_MS 10
`define FH_POLL_LIMIT_CYC (2 * `FH_PROG_CYCLE_MS * 1000000 / `FH_CLK_PERIOD_NS)

// --------------------------------------------------------------
// address fields and polling bits
// --------------------------------------------------------------
`define FH_SECT_MSB 15
`define FH_SECT_LSB 7
`define FH_TOGGLE_LO 6
`define FH_TOGGLE_HI 14

// --------------------------------------------------------------
// command sequence words
// --------------------------------------------------------------
`define FH_SEQ_ADDR_A 16'h5555
`define FH_SEQ_ADDR_B 16'h2aaa
`define FH_SEQ_D_AA 16'h00aa
`define FH_SEQ_D_55 16'h0055
`define FH_SEQ_D_LOCK 16'h00a0
`define FH_SEQ_D_EXT 16'h0080
`define FH_SEQ_D_UNLOCK 16'h0020
`define FH_SEQ_D_ERASE 16'h0010

`endif

// file: core/flash_host_pkg.sv
package flash_host_pkg;

   typedef enum logic [2:0] {OP_READ, OP_LOAD, OP_LOCK_ON, OP_LOCK_OFF, OP_ERASE_ALL} op_t;

   typedef enum logic [1:0] {SEQ_PREFIX, SEQ_UNLOCK, SEQ_ERASE} seq_t;

   typedef enum logic [1:0] {CYC_IDLE, CYC_SETUP, CYC_STROBE, CYC_HOLD} cyc_state_t;

   typedef enum logic [2:0] {ST_PWRUP, ST_IDLE, ST_SEQ, ST_WORD, ST_WINDOW, ST_POLL, ST_READ} host_state_t;

   typedef struct packed {
      cyc_state_t st;
      logic wr;
      logic [2:0] cnt;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic doe;
      logic done;
   } cyc_t;

   typedef struct packed {
      host_state_t st;
      seq_t seq;
      logic [2:0] idx;
      logic word_after;
      logic lock;
      logic [8:0] sector;
      logic [15:0] addr;
      logic [15:0] data;
      logic [19:0] tmr;
      logic poll_first;
      logic [15:0] last_poll;
      logic cyc_start;
      logic cyc_wr;
      logic [15:0] cyc_addr;
      logic [15:0] cyc_data;
      logic rsp_valid;
      logic [15:0] rsp_data;
      logic err;
   } host_t;

endpackage : flash_host_pkg

// file: core/flash_bus_cycle.sv
`timescale 1ns/1ps
`include "flash_host_map.svh"

module flash_bus_cycle
   import flash_host_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic start_i,
   input wire logic wr_i,
   input wire logic [15:0] addr_i,
   input wire logic [15:0] wdata_i,
   output logic done_o,
   output logic [15:0] rdata_o,
   output logic [15:0] word_address_lines_o,
   output logic flash_ce_n_o,
   output logic flash_oe_n_o,
   output logic flash_we_n_o,
   output logic [15:0] data_lines_o,
   output logic data_lines_oe_o,
   input wire logic [15:0] data_lines_i
);

   cyc_t q_r;
   cyc_t q_nxt;

   always_comb begin
      q_nxt = q_r;
      q_nxt.done = 1'b0;
      case (q_r.st)
         CYC_IDLE: begin
            if (start_i) begin
               q_nxt.st = CYC_SETUP;
               q_nxt.wr = wr_i;
               q_nxt.addr = addr_i;
               q_nxt.wdata = wdata_i;
               q_nxt.ce_n = 1'b0;
               q_nxt.doe = wr_i;
               q_nxt.cnt = 3'h0;
            end
         end
         CYC_SETUP: begin
            q_nxt.st = CYC_STROBE;
            if (q_r.wr) begin
               q_nxt.we_n = 1'b0;
            end else begin
               q_nxt.oe_n = 1'b0;
            end
         end
         CYC_STROBE: begin
            q_nxt.cnt = q_r.cnt + 3'h1;
            if ((q_r.wr && q_r.cnt == 3'(`FH_WE_LOW_CYC - 1)) ||
                (!q_r.wr && q_r.cnt == 3'(`FH_RD_WAIT_CYC - 1))) begin
               q_nxt.we_n = 1'b1;
               q_nxt.oe_n = 1'b1;
               if (!q_r.wr) begin
                  q_nxt.rdata = data_lines_i;
               end
               q_nxt.st = CYC_HOLD;
            end
         end
         CYC_HOLD: begin
            // data stays driven one cycle past the rising strobe
            q_nxt.ce_n = 1'b1;
            q_nxt.doe = 1'b0;
            q_nxt.done = 1'b1;
            q_nxt.st = CYC_IDLE;
         end
         default: begin
            q_nxt.st = CYC_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q_r <= '{st: CYC_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
      end else begin
         q_r <= q_nxt;
      end
   end

   assign done_o = q_r.done;
   assign rdata_o = q_r.rdata;
   assign word_address_lines_o = q_r.addr;
   assign flash_ce_n_o = q_r.ce_n;
   assign flash_oe_n_o = q_r.oe_n;
   assign flash_we_n_o = q_r.we_n;
   assign data_lines_o = q_r.wdata;
   assign data_lines_oe_o = q_r.doe;

endmodule : flash_bus_cycle

// file: core/flash_host.sv
`timescale 1ns/1ps
`include "flash_host_map.svh"

module flash_host
   import flash_host_pkg::*;
#(
   parameter int PWRUP_CYCLES = `FH_PWRUP_CYC,
   parameter int POLL_LIMIT_CYCLES = `FH_POLL_LIMIT_CYC
)
(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire op_t cmd_op_i,
   input wire logic [15:0] cmd_addr_i,
   input wire logic [15:0] cmd_data_i,
   output logic rsp_valid_o,
   output logic [15:0] rsp_data_o,
   output logic rsp_err_o,
   output logic busy_o,
   output logic command_write_lock_o,
   output logic [15:0] word_address_lines_o,
   output logic flash_ce_n_o,
   output logic flash_oe_n_o,
   output logic flash_we_n_o,
   output logic [15:0] data_lines_o,
   output logic data_lines_oe_o,
   input wire logic [15:0] data_lines_i
);

   // --------------------------------------------------------------
   // command sequence tables
   // --------------------------------------------------------------
   function automatic logic [31:0] seq_word(input seq_t s, input logic [2:0] i);
      logic [31:0] w;
      w = {`FH_SEQ_ADDR_A, `FH_SEQ_D_AA};
      case (i)
         3'h1: w = {`FH_SEQ_ADDR_B, `FH_SEQ_D_55};
         3'h2: w = (s == SEQ_PREFIX) ? {`FH_SEQ_ADDR_A, `FH_SEQ_D_LOCK} : {`FH_SEQ_ADDR_A, `FH_SEQ_D_EXT};
         3'h4: w = {`FH_SEQ_ADDR_B, `FH_SEQ_D_55};
         3'h5: w = (s == SEQ_UNLOCK) ? {`FH_SEQ_ADDR_A, `FH_SEQ_D_UNLOCK} : {`FH_SEQ_ADDR_A, `FH_SEQ_D_ERASE};
         default: w = {`FH_SEQ_ADDR_A, `FH_SEQ_D_AA};
      endcase
      return w;
   endfunction : seq_word

   function automatic logic [2:0] seq_last(input seq_t s);
      return (s == SEQ_PREFIX) ? 3'h2 : 3'h5;
   endfunction : seq_last

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   host_t q_r;
   host_t q_nxt;
   logic cyc_done;
   logic [15:0] cyc_rdata;
   logic same_sector;
   logic load_open;
   logic poll_stable;

   assign same_sector = (cmd_addr_i[`FH_SECT_MSB:`FH_SECT_LSB] == q_r.sector);
   assign load_open = (q_r.st == ST_WINDOW) && (cmd_op_i == OP_LOAD) && same_sector &&
                      (q_r.tmr < 20'(`FH_LOAD_WIN_CYC - `FH_LOAD_MARGIN_CYC));
   // toggle bits unchanged across two reads
   assign poll_stable = !q_r.poll_first &&
                        (cyc_rdata[`FH_TOGGLE_LO] == q_r.last_poll[`FH_TOGGLE_LO]) &&
                        (cyc_rdata[`FH_TOGGLE_HI] == q_r.last_poll[`FH_TOGGLE_HI]);

   always_comb begin
      q_nxt = q_r;
      q_nxt.cyc_start = 1'b0;
      q_nxt.rsp_valid = 1'b0;
      cmd_ready_o = 1'b0;
      case (q_r.st)
         ST_PWRUP: begin
            q_nxt.tmr = q_r.tmr + 20'h1;
            if (q_r.tmr >= 20'(PWRUP_CYCLES - 1)) begin
               q_nxt.tmr = 20'h0;
               q_nxt.st = ST_IDLE;
            end
         end
         ST_IDLE: begin
            cmd_ready_o = 1'b1;
            if (cmd_valid_i) begin
               q_nxt.err = 1'b0;
               q_nxt.addr = cmd_addr_i;
               q_nxt.data = cmd_data_i;
               q_nxt.sector = cmd_addr_i[`FH_SECT_MSB:`FH_SECT_LSB];
               q_nxt.idx = 3'h0;
               q_nxt.word_after = (cmd_op_i == OP_LOAD);
               q_nxt.cyc_start = 1'b1;
               q_nxt.cyc_wr = 1'b1;
               case (cmd_op_i)
                  OP_READ: begin
                     q_nxt.cyc_wr = 1'b0;
                     q_nxt.cyc_addr = cmd_addr_i;
                     q_nxt.st = ST_READ;
                  end
                  OP_LOAD: begin
                     q_nxt.seq = SEQ_PREFIX;
                     {q_nxt.cyc_addr, q_nxt.cyc_data} = q_r.lock ? seq_word(SEQ_PREFIX, 3'h0) : {cmd_addr_i, cmd_data_i};
                     q_nxt.st = q_r.lock ? ST_SEQ : ST_WORD;
                  end
                  OP_LOCK_ON: begin
                     q_nxt.seq = SEQ_PREFIX;
                     q_nxt.lock = 1'b1;
                     {q_nxt.cyc_addr, q_nxt.cyc_data} = seq_word(SEQ_PREFIX, 3'h0);
                     q_nxt.st = ST_SEQ;
                  end
                  OP_LOCK_OFF: begin
                     q_nxt.seq = SEQ_UNLOCK;
                     q_nxt.lock = 1'b0;
                     {q_nxt.cyc_addr, q_nxt.cyc_data} = seq_word(SEQ_UNLOCK, 3'h0);
                     q_nxt.st = ST_SEQ;
                  end
                  default: begin
                     q_nxt.seq = SEQ_ERASE;
                     {q_nxt.cyc_addr, q_nxt.cyc_data} = seq_word(SEQ_ERASE, 3'h0);
                     q_nxt.st = ST_SEQ;
                  end
               endcase
            end
         end
         ST_SEQ: begin
            if (cyc_done) begin
               q_nxt.cyc_start = 1'b1;
               q_nxt.cyc_wr = 1'b1;
               if (q_r.idx == seq_last(q_r.seq)) begin
                  if (q_r.word_after) begin
                     q_nxt.cyc_addr = q_r.addr;
                     q_nxt.cyc_data = q_r.data;
                     q_nxt.st = ST_WORD;
                  end else begin
                     q_nxt.cyc_start = 1'b0;
                     q_nxt.tmr = 20'h0;
                     q_nxt.st = ST_WINDOW;
                  end
               end else begin
                  q_nxt.idx = q_r.idx + 3'h1;
                  {q_nxt.cyc_addr, q_nxt.cyc_data} = seq_word(q_r.seq, q_r.idx + 3'h1);
               end
            end
         end
         ST_WORD: begin
            if (cyc_done) begin
               q_nxt.tmr = 20'h0;
               q_nxt.st = ST_WINDOW;
            end
         end
         ST_WINDOW: begin
            // any word index of the sector
            cmd_ready_o = load_open;
            q_nxt.tmr = q_r.tmr + 20'h1;
            if (cmd_valid_i && load_open) begin
               q_nxt.cyc_start = 1'b1;
               q_nxt.cyc_wr = 1'b1;
               q_nxt.cyc_addr = cmd_addr_i;
               q_nxt.cyc_data = cmd_data_i;
               q_nxt.st = ST_WORD;
            end else if (q_r.tmr >= 20'(`FH_LOAD_WIN_CYC + `FH_LOAD_MARGIN_CYC)) begin
               // other sector waits for this cycle
               q_nxt.cyc_start = 1'b1;
               q_nxt.cyc_wr = 1'b0;
               q_nxt.poll_first = 1'b1;
               q_nxt.tmr = 20'h0;
               q_nxt.st = ST_POLL;
            end
         end
         ST_POLL: begin
            if (q_r.tmr != 20'hfffff) begin
               q_nxt.tmr = q_r.tmr + 20'h1;
            end
            if (cyc_done) begin
               q_nxt.last_poll = cyc_rdata;
               q_nxt.poll_first = 1'b0;
               if (poll_stable || q_r.tmr >= 20'(POLL_LIMIT_CYCLES)) begin
                  q_nxt.err = !poll_stable;
                  q_nxt.rsp_valid = 1'b1;
                  q_nxt.rsp_data = cyc_rdata;
                  q_nxt.st = ST_IDLE;
               end else begin
                  q_nxt.cyc_start = 1'b1;
               end
            end
         end
         ST_READ: begin
            if (cyc_done) begin
               q_nxt.rsp_valid = 1'b1;
               q_nxt.rsp_data = cyc_rdata;
               q_nxt.st = ST_IDLE;
            end
         end
         default: begin
            q_nxt.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q_r <= '{st: ST_PWRUP, seq: SEQ_PREFIX, default: '0};
      end else begin
         q_r <= q_nxt;
      end
   end

   // --------------------------------------------------------------
   // pin sequencer
   // --------------------------------------------------------------
   flash_bus_cycle u_cycle (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .start_i(q_r.cyc_start),
      .wr_i(q_r.cyc_wr),
      .addr_i(q_r.cyc_addr),
      .wdata_i(q_r.cyc_data),
      .done_o(cyc_done),
      .rdata_o(cyc_rdata),
      .word_address_lines_o(word_address_lines_o),
      .flash_ce_n_o(flash_ce_n_o),
      .flash_oe_n_o(flash_oe_n_o),
      .flash_we_n_o(flash_we_n_o),
      .data_lines_o(data_lines_o),
      .data_lines_oe_o(data_lines_oe_o),
      .data_lines_i(data_lines_i)
   );

   assign rsp_valid_o = q_r.rsp_valid;
   assign rsp_data_o = q_r.rsp_data;
   assign rsp_err_o = q_r.err;
   assign busy_o = (q_r.st != ST_IDLE);
   // lock mirror starts cleared: the device is shipped unlocked
   assign command_write_lock_o = q_r.lock;

endmodule : flash_host

// file: bench/flash_host_assertions.sv
`timescale 1ns/1ps
module flash_host_assertions
   import flash_host_pkg::*;
#(
   parameter int PWRUP_CYCLES = 20,
   parameter int POLL_LIMIT_CYCLES = 2000
)
(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic cmd_valid_i,
   input wire logic cmd_ready_o,
   input wire op_t cmd_op_i,
   input wire logic [15:0] cmd_addr_i,
   input wire logic [15:0] cmd_data_i,
   input wire logic rsp_valid_o,
   input wire logic [15:0] rsp_data_o,
   input wire logic rsp_err_o,
   input wire logic busy_o,
   input wire logic command_write_lock_o,
   input wire logic [15:0] word_address_lines_o,
   input wire logic flash_ce_n_o,
   input wire logic flash_oe_n_o,
   input wire logic flash_we_n_o,
   input wire logic [15:0] data_lines_o,
   input wire logic data_lines_oe_o,
   input wire logic [15:0] data_lines_i
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   // ----------------------------------------------------------
   // strobe shapes
   // ----------------------------------------------------------
   sequence we_low_tail;
      !flash_we_n_o ##1 flash_we_n_o;
   endsequence
   sequence oe_low_tail;
      !flash_oe_n_o [*3] ##1 flash_oe_n_o;
   endsequence
   sequence take;
      cmd_valid_i && cmd_ready_o;
   endsequence
   a_we_pulse_len: assert property ($fell(flash_we_n_o) |-> ##1 we_low_tail)
      else $error("write strobe width wrong");
   a_oe_pulse_len: assert property ($fell(flash_oe_n_o) |-> ##1 oe_low_tail)
      else $error("read strobe width wrong");
   a_read_excl: assert property (!flash_oe_n_o |-> flash_we_n_o && !flash_ce_n_o)
      else $error("read without select or with write");
   a_strobe_sel: assert property (!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o && data_lines_oe_o)
      else $error("write strobe outside select");
   a_drive_gap: assert property (data_lines_oe_o |-> flash_oe_n_o)
      else $error("host drives while device may drive");
   a_strobe_stable: assert property (
      !flash_we_n_o && !$past(flash_we_n_o) |-> $stable(word_address_lines_o) && $stable(data_lines_o))
      else $error("address or data moved in strobe");
   a_select_setup: assert property ($fell(flash_ce_n_o) |-> flash_oe_n_o && flash_we_n_o)
      else $error("strobe at select edge");
   a_select_hold: assert property (
      $rose(flash_ce_n_o) |-> flash_we_n_o && $past(flash_we_n_o) && $past(flash_oe_n_o))
      else $error("select released during strobe");
   a_read_answer: assert property (take ##0 (cmd_op_i == OP_READ) |-> ##[8:10] rsp_valid_o)
      else $error("read answer late");
   a_take_busy: assert property (take |=> busy_o && !rsp_err_o)
      else $error("not busy after take");
endmodule : flash_host_assertions

bind flash_host flash_host_assertions #(.PWRUP_CYCLES(PWRUP_CYCLES), .POLL_LIMIT_CYCLES(POLL_LIMIT_CYCLES)) chk (
   .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
   .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i), .rsp_valid_o(rsp_valid_o),
   .rsp_data_o(rsp_data_o), .rsp_err_o(rsp_err_o), .busy_o(busy_o), .command_write_lock_o(command_write_lock_o),
   .word_address_lines_o(word_address_lines_o), .flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o),
   .flash_we_n_o(flash_we_n_o), .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o),
   .data_lines_i(data_lines_i));

// file: bench/flash_device_model.sv
`timescale 1ns/1ps
module flash_device_model #(
   parameter int WIN_NS = 150000,
   parameter int PROG_NS = 20000,
   parameter int PWRUP_NS = 500
)
(
   input wire logic [15:0] addr_i,
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [15:0] data_i,
   output logic [15:0] data_o
);
   logic [15:0] mem [0:65535];
   logic [15:0] ladr;
   logic [15:0] ldat;
   logic [15:0] qa [$];
   logic [15:0] qd [$];
   logic lock = 1'b0;
   logic busy = 1'b0;
   logic loading = 1'b0;
   logic tog = 1'b0;
   logic drive;
   realtime t_fall;
   realtime t_rise;
   wire strobe_n = ce_n_i | we_n_i;
   // drives only while selected for read
   assign drive = !ce_n_i && !oe_n_i && we_n_i;
   initial begin
      foreach (mem[i]) mem[i] = 16'hffff;
   end
   // busy reads give polling status
   // released lines must not keep the last value
   always @(drive) begin
      if (drive !== 1'b1) begin
         data_o = ~data_o;
      end else if (busy) begin
         data_o = ldat ^ 16'h8080;
         data_o[6] = tog;
         data_o[14] = tog;
         tog = ~tog;
      end else begin
         data_o = mem[addr_i];
      end
   end
   // address on the later falling edge
   always @(negedge strobe_n) begin
      t_fall = $realtime;
      ladr = addr_i;
   end
   // data on the earlier rising edge, filtered
   always @(posedge strobe_n) begin
      if (oe_n_i && !busy && $realtime - t_fall >= 15 && $realtime >= PWRUP_NS) begin
         ldat = data_i;
         qa.push_back(ladr);
         qd.push_back(data_i);
         t_rise = $realtime;
         loading = 1'b1;
      end
   end
   // load period ends after a quiet gap
   always #100 begin
      if (loading && $realtime - t_rise > WIN_NS) begin
         loading = 1'b0;
         program_sector();
      end
   end
   task automatic program_sector;
      int k;
      bit pre;
      pre = qa.size() >= 3 && qa[0] == 16'h5555 && qd[0] == 16'h00aa && qa[1] == 16'h2aaa
         && qd[1] == 16'h0055 && qa[2] == 16'h5555;
      busy = 1'b1;
      #(PROG_NS);
      if (pre && qd[2] == 16'h0080 && qa.size() >= 6) begin
         if (qd[5] == 16'h0020) lock = 1'b0;
         else if (qd[5] == 16'h0010) foreach (mem[i]) mem[i] = 16'hffff;
      end else if ((pre && qd[2] == 16'h00a0) || !lock) begin
         k = (pre && qd[2] == 16'h00a0) ? 3 : 0;
         if (k == 3) lock = 1'b1;
         if (qa.size() > k) begin
            for (int i = 0; i < 128; i++) mem[{qa[k][15:7], i[6:0]}] = 16'hffff;
            for (int i = k; i < qa.size(); i++) mem[qa[i]] = qd[i];
         end
      end
      qa.delete();
      qd.delete();
      busy = 1'b0;
   endtask : program_sector
endmodule : flash_device_model

// file: bench/flash_host_bench.sv
`timescale 1ns/1ps
module flash_host_bench
   import flash_host_pkg::*;
;
   localparam int PWR = 20;
   localparam int PLIM = 2000;
   localparam int PWAIT = 8000;
   logic core_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic cmd_valid_i = 1'b0;
   op_t cmd_op_i = OP_READ;
   logic [15:0] cmd_addr_i = 16'h0000;
   logic [15:0] cmd_data_i = 16'h0000;
   logic cmd_ready_o, rsp_valid_o, rsp_err_o, busy_o, command_write_lock_o;
   logic flash_ce_n_o, flash_oe_n_o, flash_we_n_o, data_lines_oe_o;
   logic [15:0] rsp_data_o, word_address_lines_o, data_lines_o, dev_data, bus, d;
   int mismatches = 0;
   int compares = 0;
   assign bus = data_lines_oe_o ? data_lines_o : dev_data;
   always #25 core_clk_i = ~core_clk_i;
   flash_host #(.PWRUP_CYCLES(PWR), .POLL_LIMIT_CYCLES(PLIM)) uut (
      .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
      .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i), .rsp_valid_o(rsp_valid_o),
      .rsp_data_o(rsp_data_o), .rsp_err_o(rsp_err_o), .busy_o(busy_o), .command_write_lock_o(command_write_lock_o),
      .word_address_lines_o(word_address_lines_o), .flash_ce_n_o(flash_ce_n_o), .flash_oe_n_o(flash_oe_n_o),
      .flash_we_n_o(flash_we_n_o), .data_lines_o(data_lines_o), .data_lines_oe_o(data_lines_oe_o),
      .data_lines_i(bus));
   flash_device_model dev (.addr_i(word_address_lines_o), .ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o),
      .we_n_i(flash_we_n_o), .data_i(bus), .data_o(dev_data));
   // ----------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask : check
   task automatic conclude;
      $display("counts: compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude
   task automatic hang(input string what);
      mismatches++;
      $display("MISMATCH t=%0t timeout in %s", $time, what);
      conclude();
   endtask : hang
   // request held until the edge that takes it
   task automatic issue(input op_t op, input logic [15:0] a, input logic [15:0] v);
      int n;
      @(posedge core_clk_i);
      cmd_op_i <= op;
      cmd_addr_i <= a;
      cmd_data_i <= v;
      cmd_valid_i <= 1'b1;
      n = 0;
      @(negedge core_clk_i);
      while (cmd_ready_o !== 1'b1 && n < PWAIT) begin
         @(negedge core_clk_i);
         n++;
      end
      if (n >= PWAIT) hang("command take");
      @(posedge core_clk_i);
      cmd_valid_i <= 1'b0;
   endtask : issue
   task automatic wait_rsp(output logic [15:0] v, input int lim);
      int n;
      n = 0;
      do begin
         @(negedge core_clk_i);
         n++;
      end while (rsp_valid_o !== 1'b1 && n < lim);
      if (n >= lim) hang("response");
      v = rsp_data_o;
   endtask : wait_rsp
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      logic [15:0] v;
      issue(OP_READ, a, 16'h0000);
      wait_rsp(v, 50);
      check(v, e, "read data");
   endtask : rd
   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   task automatic t_reset;
      int n;
      check({15'h0000, busy_o}, 16'h0001, "busy in reset");
      check({15'h0000, flash_ce_n_o}, 16'h0001, "select idle");
      check({15'h0000, command_write_lock_o}, 16'h0000, "lock at reset");
      arst_n_i <= 1'b1;
      repeat (5) @(negedge core_clk_i);
      check({15'h0000, cmd_ready_o}, 16'h0000, "ready in power-up");
      n = 0;
      while (cmd_ready_o !== 1'b1 && n < 40) begin
         @(negedge core_clk_i);
         n++;
      end
      if (n >= 40) hang("power-up");
      rd(16'h0123, 16'hffff);
      $display("test reset done");
   endtask : t_reset
   task automatic t_program;
      issue(OP_LOAD, 16'h0285, 16'h1234);
      issue(OP_LOAD, 16'h0282, 16'ha5a5);
      issue(OP_LOAD, 16'h02ff, 16'h0f0f);
      cmd_op_i <= OP_READ;
      // let the last word finish so the open window itself is probed
      repeat (12) @(negedge core_clk_i);
      check({15'h0000, cmd_ready_o}, 16'h0000, "read in load period");
      @(posedge core_clk_i);
      cmd_op_i <= OP_LOAD;
      cmd_addr_i <= 16'h0305;
      @(negedge core_clk_i);
      check({15'h0000, cmd_ready_o}, 16'h0000, "other sector in load period");
      wait_rsp(d, PWAIT);
      check(d, 16'h0f0f, "final polled word");
      check({15'h0000, rsp_err_o}, 16'h0000, "poll error");
      rd(16'h0285, 16'h1234);
      rd(16'h0282, 16'ha5a5);
      rd(16'h02ff, 16'h0f0f);
      rd(16'h0280, 16'hffff);
      rd(16'h0305, 16'hffff);
      $display("test program done");
   endtask : t_program
   task automatic t_lock;
      issue(OP_LOCK_ON, 16'h0000, 16'h0000);
      wait_rsp(d, PWAIT);
      check({15'h0000, command_write_lock_o}, 16'h0001, "lock on");
      issue(OP_LOAD, 16'h0282, 16'h4242);
      wait_rsp(d, PWAIT);
      rd(16'h0282, 16'h4242);
      rd(16'h0285, 16'hffff);
      issue(OP_LOCK_OFF, 16'h0000, 16'h0000);
      wait_rsp(d, PWAIT);
      check({15'h0000, command_write_lock_o}, 16'h0000, "lock off");
      $display("test lock done");
   endtask : t_lock
   task automatic t_erase;
      issue(OP_ERASE_ALL, 16'h0000, 16'h0000);
      wait_rsp(d, PWAIT);
      check({15'h0000, rsp_err_o}, 16'h0000, "erase poll error");
      rd(16'h0282, 16'hffff);
      $display("test erase done");
   endtask : t_erase
   initial begin
      repeat (20) @(posedge core_clk_i);
      t_reset();
      t_program();
      t_lock();
      t_erase();
      conclude();
   end
endmodule : flash_host_bench
